// file: hdl/pdsau_defines.vh
`ifndef PDSAU_DEFINES_VH
`define PDSAU_DEFINES_VH

// Register byte offsets on the register bus
`define PDSAU_OFS_RDPAGE 8'h00
`define PDSAU_OFS_WRPAGE 8'h04
`define PDSAU_OFS_STATUS 8'h08
`define PDSAU_OFS_MASK 8'h0c

// Page register widths and reset values
`define PDSAU_RDPAGE_W 10
`define PDSAU_WRPAGE_W 9
`define PDSAU_RDPAGE_RST 10'h001
`define PDSAU_WRPAGE_RST 9'h001

// Boundary pages
`define PDSAU_PG_EDS_LAST 9'h1ff
`define PDSAU_PG_PSV_FIRST 10'h200
`define PDSAU_PG_PSV_LSW_LAST 10'h2ff
`define PDSAU_PG_PSV_MSW_FIRST 10'h300
`define PDSAU_PG_PSV_LAST 10'h3ff
`define PDSAU_PG_ONE 10'h001

// Highest base address that is always reachable
`define PDSAU_BASE_FIXED_TOP 16'h2fff

// Addressing mode codes
`define PDSAU_MODE_PLAIN 3'h0
`define PDSAU_MODE_PRE 3'h1
`define PDSAU_MODE_POST 3'h2
`define PDSAU_MODE_REGOFS 3'h3
`define PDSAU_MODE_MODULO 3'h4
`define PDSAU_MODE_BITREV 3'h5

// Status and mask bit positions
`define PDSAU_ST_RD_TRAP 0
`define PDSAU_ST_WR_TRAP 1
`define PDSAU_ST_RD_PGCHG 2
`define PDSAU_ST_WR_PGCHG 3
`define PDSAU_ST_W 4

// Bus responses
`define PDSAU_RESP_OKAY 2'h0
`define PDSAU_RESP_SLVERR 2'h2

`endif

// file: hdl/pdsau_top.v
`include "pdsau_defines.vh"

module pdsau_top (
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Core effective address request
    input wire ea_valid,
    input wire ea_is_write,
    input wire [2:0] ea_mode,
    input wire [15:0] ea_start,
    input wire [15:0] effective_address,
    input wire ea_overflow,
    input wire ea_underflow,
    // Memory side
    output reg mem_valid,
    output reg mem_is_write,
    output reg mem_to_program,
    output reg [23:0] mem_addr,
    output reg [15:0] ea_fixed,
    output reg addr_trap,
    output reg irq
);

    reg [`PDSAU_RDPAGE_W-1:0] read_page_q;
    reg [`PDSAU_WRPAGE_W-1:0] write_page_q;
    reg [`PDSAU_ST_W-1:0] status_q;
    reg [`PDSAU_ST_W-1:0] mask_q;
    reg [7:0] awaddr_q;
    reg aw_held_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_held_q;

    ////////////////////////////////////////////////////////////////////////
    // Address translation, combinational

    reg [9:0] cur_page;
    reg [9:0] new_page;
    reg [15:0] ea_out;
    reg [23:0] addr_out;
    reg to_prog;
    reg trap;
    reg page_chg;
    reg start_paged;
    reg indirect;
    reg wrap_mode;

    always @* begin
        cur_page = ea_is_write ? {1'b0, write_page_q} : read_page_q;
        new_page = cur_page;
        ea_out = effective_address;
        start_paged = ea_start[15];
        indirect = (ea_mode == `PDSAU_MODE_PRE) || (ea_mode == `PDSAU_MODE_POST);
        wrap_mode = (ea_mode == `PDSAU_MODE_REGOFS) || (ea_mode == `PDSAU_MODE_MODULO) ||
            (ea_mode == `PDSAU_MODE_BITREV);
        // Page crossing handling
        if (start_paged && (ea_overflow || ea_underflow)) begin
            if (wrap_mode) begin
                ea_out[15] = 1'b1;
            end else if (indirect) begin
                ea_out[15] = 1'b0;
                if (ea_overflow) begin
                    if (cur_page == `PDSAU_PG_PSV_LSW_LAST && !ea_is_write) begin
                        new_page = `PDSAU_PG_PSV_MSW_FIRST;
                        ea_out[15] = 1'b1;
                    end else if (cur_page[8:0] == `PDSAU_PG_EDS_LAST && !cur_page[9]) begin
                        new_page = cur_page;
                    end else if (cur_page == `PDSAU_PG_PSV_LAST) begin
                        new_page = cur_page;
                    end else begin
                        new_page = cur_page + 10'h001;
                        ea_out[15] = 1'b1;
                    end
                end else begin
                    if (cur_page == `PDSAU_PG_PSV_MSW_FIRST && !ea_is_write) begin
                        new_page = `PDSAU_PG_PSV_LSW_LAST;
                        ea_out[15] = 1'b1;
                    end else if (!ea_is_write && (cur_page == `PDSAU_PG_ONE || cur_page == `PDSAU_PG_PSV_FIRST)) begin
                        new_page = cur_page;
                    end else begin
                        new_page = cur_page - 10'h001;
                        ea_out[15] = 1'b1;
                    end
                end
            end
        end
        page_chg = (new_page != cur_page);
        // Extended address: page zero below bit 15, paged above
        if (ea_out[15]) begin
            addr_out = {cur_page[8:0], ea_out[14:0]};
        end else begin
            addr_out = {8'h00, ea_out};
        end
        to_prog = !ea_is_write && ea_out[15] && (cur_page >= `PDSAU_PG_PSV_FIRST);
        trap = ea_out[15] && ((cur_page == 10'h000) || (ea_is_write && cur_page[9]));
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode helpers

    wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    // Registers change once, when both channels are captured
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    wire wr_lo = wr_strb[0];
    wire wr_hi = wr_strb[1];
    wire [9:0] wr_rdpg = {wr_hi ? wr_data[9:8] : read_page_q[9:8], wr_lo ? wr_data[7:0] : read_page_q[7:0]};
    wire [8:0] wr_wrpg = {wr_hi ? wr_data[8] : write_page_q[8], wr_lo ? wr_data[7:0] : write_page_q[7:0]};
    wire core_upd = ea_valid && !trap && page_chg;
    wire [`PDSAU_ST_W-1:0] events = {4{ea_valid}} &
        {ea_is_write & core_upd, ~ea_is_write & core_upd, ea_is_write & trap, ~ea_is_write & trap};
    wire wr_map = (wr_addr == `PDSAU_OFS_RDPAGE) || (wr_addr == `PDSAU_OFS_WRPAGE) ||
        (wr_addr == `PDSAU_OFS_STATUS) || (wr_addr == `PDSAU_OFS_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Page registers, status and mask

    always @(posedge aclk) begin
        if (!aresetn) begin
            read_page_q <= `PDSAU_RDPAGE_RST;
            write_page_q <= `PDSAU_WRPAGE_RST;
            status_q <= {`PDSAU_ST_W{1'b0}};
            mask_q <= {`PDSAU_ST_W{1'b0}};
        end else begin
            // Core page steps take priority over software writes
            if (core_upd && !ea_is_write) begin
                read_page_q <= new_page;
            end else if (wr_fire && wr_addr == `PDSAU_OFS_RDPAGE && wr_rdpg != 10'h000) begin
                read_page_q <= wr_rdpg;
            end
            if (core_upd && ea_is_write) begin
                write_page_q <= new_page[8:0];
            end else if (wr_fire && wr_addr == `PDSAU_OFS_WRPAGE && wr_wrpg != 9'h000) begin
                write_page_q <= wr_wrpg;
            end
            // Sticky status, set wins over clear
            if (wr_fire && wr_addr == `PDSAU_OFS_STATUS && wr_lo) begin
                status_q <= (status_q & ~wr_data[`PDSAU_ST_W-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
            if (wr_fire && wr_addr == `PDSAU_OFS_MASK && wr_lo) begin
                mask_q <= wr_data[`PDSAU_ST_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channels

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDSAU_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            // Capture each channel once; ready is a one-cycle pulse
            if (s_axi_awvalid && !aw_held_q && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `PDSAU_RESP_OKAY : `PDSAU_RESP_SLVERR;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PDSAU_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PDSAU_RESP_OKAY;
                case (s_axi_araddr)
                    `PDSAU_OFS_RDPAGE: s_axi_rdata <= {22'h000000, read_page_q};
                    `PDSAU_OFS_WRPAGE: s_axi_rdata <= {23'h000000, write_page_q};
                    `PDSAU_OFS_STATUS: s_axi_rdata <= {28'h0000000, status_q};
                    `PDSAU_OFS_MASK: s_axi_rdata <= {28'h0000000, mask_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `PDSAU_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered memory-side outputs and interrupt

    always @(posedge aclk) begin
        if (!aresetn) begin
            mem_valid <= 1'b0;
            mem_is_write <= 1'b0;
            mem_to_program <= 1'b0;
            mem_addr <= 24'h000000;
            ea_fixed <= 16'h0000;
            addr_trap <= 1'b0;
            irq <= 1'b0;
        end else begin
            mem_valid <= ea_valid && !trap;
            mem_is_write <= ea_is_write;
            mem_to_program <= ea_valid && to_prog;
            mem_addr <= addr_out;
            ea_fixed <= ea_out;
            addr_trap <= ea_valid && trap;
            irq <= |(status_q & mask_q);
        end
    end

endmodule

// file: dv/pdsau_sva.sv
module pdsau_sva (
    input wire aclk,
    input wire aresetn,
    input wire ea_valid,
    input wire [2:0] ea_mode,
    input wire [15:0] ea_start,
    input wire [15:0] effective_address,
    input wire ea_overflow,
    input wire ea_underflow,
    input wire mem_valid,
    input wire mem_is_write,
    input wire mem_to_program,
    input wire [23:0] mem_addr,
    input wire [15:0] ea_fixed,
    input wire addr_trap,
    input wire irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Exactly one result per request, none without
    chk_one_result: assert property (ea_valid |=> mem_valid ^ addr_trap)
        else $error("request without single result");
    chk_no_request: assert property (!ea_valid |=> !mem_valid && !addr_trap)
        else $error("result without request");
    // Offset bits pass, bit 15 only adjusted
    chk_low_start: assert property (ea_valid && !ea_start[15] |=> ea_fixed == $past(effective_address))
        else $error("base start address altered");
    chk_low_bits: assert property (ea_valid |=> ea_fixed[14:0] == $past(effective_address[14:0]))
        else $error("offset bits altered");
    chk_wrap_mode: assert property (ea_valid && ea_start[15] && ea_mode inside {3'h3, 3'h4, 3'h5}
        && (ea_overflow || ea_underflow) |=> ea_fixed[15])
        else $error("wrap mode cleared bit 15");
    chk_plain_keep: assert property (ea_valid && ea_mode == 3'h0 |=> ea_fixed[15] == $past(effective_address[15]))
        else $error("plain mode changed bit 15");
    // Extended address build
    chk_base_page: assert property (mem_valid && !ea_fixed[15] |-> mem_addr[23:15] == 9'h000)
        else $error("base access not on page zero");
    chk_paged_addr: assert property (mem_valid && ea_fixed[15] && !mem_to_program |->
        mem_addr[23:15] != 9'h000 && mem_addr[14:0] == ea_fixed[14:0])
        else $error("paged address malformed");
    chk_prog_read: assert property (mem_to_program |-> mem_valid && !mem_is_write && ea_fixed[15])
        else $error("program path misused");
    chk_reset_out: assert property (disable iff (1'b0) !aresetn |=> !mem_valid && !addr_trap && !irq)
        else $error("outputs active in reset");
endmodule
bind pdsau_top pdsau_sva i_sva (.*);

// file: dv/pdsau_core_model.sv
module pdsau_core_model (
    input wire aclk,
    output logic ea_valid,
    output logic ea_is_write,
    output logic [2:0] ea_mode,
    output logic [15:0] ea_start,
    output logic [15:0] effective_address,
    output logic ea_overflow,
    output logic ea_underflow
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ea_valid, ea_is_write, ea_mode, ea_start, effective_address, ea_overflow, ea_underflow} = '0;
    // One modified-address request, flags only for paged starts
    task automatic issue(input logic w, input logic [2:0] m, input logic [15:0] s, input logic [15:0] d);
        ea_valid <= 1'b1;
        ea_is_write <= w;
        ea_mode <= m;
        ea_start <= s;
        effective_address <= s + d;
        ea_overflow <= s[15] && !d[15] && 16'(s + d) < s;
        ea_underflow <= s[15] && d[15] && !(s[15:0] + d[15:0] >= 17'h8000 && 16'(s + d) >= 16'h8000);
        @(posedge aclk);
    endtask
    // Idle: start and address lines churn so stale values are never trusted
    task automatic idle;
        ea_valid <= 1'b0;
        ea_start <= ~ea_start;
        effective_address <= ~effective_address;
        @(posedge aclk);
    endtask
endmodule

// file: dv/tb_top.sv
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin mismatches++; $display("[FAIL] %s exp %h seen %h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire ea_valid, ea_is_write, ea_overflow, ea_underflow, mem_valid, mem_is_write, mem_to_program, addr_trap, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] ea_mode;
    wire [15:0] ea_start, effective_address, ea_fixed;
    wire [23:0] mem_addr;
    int mismatches = 0, checks = 0, cyc = 0;
    logic [31:0] seed = 32'd48;
    logic [9:0] rp = 10'h001;
    logic [8:0] wp = 9'h001;
    logic [9:0] pages[8] = '{10'h001, 10'h002, 10'h1ff, 10'h200, 10'h2ff, 10'h300, 10'h3ff, 10'h3fe};
    logic [26:0] core_q[$];
    logic [33:0] rd_q[$];
    logic [26:0] ce, cs;
    logic [33:0] re;
    always #25 aclk = ~aclk;
    pdsau_top i_dut (.*);
    pdsau_core_model i_core (.*);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // Register bus write, response checked on handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    // Register bus read, expectation queued for the monitor
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rd_q.push_back(e);
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Core request with page model: {trap, program, bit15, address}
    task automatic req(input logic w, input logic [2:0] m, input logic [15:0] s, input logic [15:0] d);
        logic [15:0] e;
        logic ov, un, f, p;
        logic [9:0] pg, np;
        e = s + d;
        ov = s[15] && !d[15] && e < s;
        un = s[15] && d[15] && !e[15];
        pg = w ? {1'b0, wp} : rp;
        np = pg;
        f = (s[15] && (ov || un) && m != 3'h0) ? 1'b1 : e[15];
        if (s[15] && (ov || un) && (m == 3'h1 || m == 3'h2)) begin
            np = ov ? pg + 10'h1 : pg - 10'h1;
            if (ov ? (pg == 10'h1ff || pg == 10'h3ff) : (!w && (pg == 10'h001 || pg == 10'h200))) begin
                np = pg;
                f = 1'b0;
            end
        end
        p = !w && f && pg >= 10'h200;
        core_q.push_back((f && pg == 10'h0) ? {1'b1, 26'h0} : {1'b0, p, f, 9'h0, e[14:0]}
            | (f && !p ? {3'h0, pg[8:0], 15'h0} : 27'h0));
        if (w) wp = np[8:0];
        else rp = np;
        i_core.issue(w, m, s, d);
    endtask
    task automatic finish_test;
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Result monitor and cycle limit
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
        if (aresetn && (mem_valid || addr_trap)) begin
            ce = core_q.size() ? core_q.pop_front() : 'x;
            cs = addr_trap ? {1'b1, 26'h0} : {1'b0, mem_to_program, ea_fixed[15],
                mem_to_program ? {9'h0, mem_addr[14:0]} : mem_addr};
            `CHK("core", ce, cs)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            re = rd_q.size() ? rd_q.pop_front() : 'x;
            `CHK("read", re, {s_axi_rresp, s_axi_rdata})
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 34'h001);
        rd(8'h04, 34'h001);
        rd(8'h10, {2'h2, 32'h0});
        wr(8'h14, 32'h5, 2'h2);
        wr(8'h00, 32'h0, 2'h0);
        rd(8'h00, 34'h001);
        // Every page boundary in every addressing mode
        foreach (pages[i]) for (int m = 0; m < 6; m++) begin
            wr(8'h00, {22'h0, pages[i]}, 2'h0);
            rp = pages[i];
            wr(8'h04, {23'h0, pages[i][8:0] ^ 9'h1ff}, 2'h0);
            if (pages[i][8:0] != 9'h1ff) wp = pages[i][8:0] ^ 9'h1ff;
            seed = xs(seed);
            req(1'b1, m[2:0], 16'hfff0 | seed[3:0], 16'h0010);
            req(1'b0, m[2:0], 16'hfff0 | seed[7:4], 16'h0010);
            req(1'b0, m[2:0], 16'h8000 | seed[11:8], 16'hffe0);
            req(1'b0, m[2:0], 16'h8000 | seed[15:12], 16'hffe0);
            req(1'b1, m[2:0], 16'h8000 | seed[11:8], 16'hffe0);
            req(seed[20], m[2:0], seed[31:16], 16'h0000);
            i_core.idle();
            rd(8'h00, {24'h0, rp});
            rd(8'h04, {25'h0, wp});
        end
        // Write page stepped down to zero, then a paged write
        wr(8'h04, 32'h1, 2'h0);
        wp = 9'h001;
        req(1'b1, 3'h1, 16'h8004, 16'hfff0);
        req(1'b1, 3'h0, 16'h9000, 16'h0000);
        i_core.idle();
        rd(8'h04, 34'h0);
        rd(8'h08, 34'h00e);
        `CHK("irq", 1'b0, irq)
        wr(8'h0c, 32'hf, 2'h0);
        repeat (3) @(posedge aclk);
        `CHK("irq", 1'b1, irq)
        wr(8'h08, 32'he, 2'h0);
        repeat (3) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        rd(8'h08, 34'h0);
        repeat (2) @(posedge aclk);
        `CHK("pending", 0, core_q.size() + rd_q.size())
        finish_test();
    end
endmodule
